/* peripheral_dma_consts.vh */
// Constants for the peripheral DMA engine and its channel slots
`ifndef PERIPHERAL_DMA_CONSTS_VH
`define PERIPHERAL_DMA_CONSTS_VH

// Slot population: ten full duplex, one receive only, one half duplex
`define NUM_SLOTS 12
`define RXO_SLOT 10
`define HDX_SLOT 11
`define SLOT_MSB 12
`define SLOT_LSB 9

// Slot modes
`define MODE_FULL 2'h0
`define MODE_RX_ONLY 2'h1
`define MODE_HALF 2'h2

// Register offsets inside each peripheral window
`define OFF_RX_CUR_PTR 9'h100
`define OFF_RX_CUR_CNT 9'h104
`define OFF_TX_CUR_PTR 9'h108
`define OFF_TX_CUR_CNT 9'h10C
`define OFF_RX_NXT_PTR 9'h110
`define OFF_RX_NXT_CNT 9'h114
`define OFF_TX_NXT_PTR 9'h118
`define OFF_TX_NXT_CNT 9'h11C
`define OFF_XFER_CTRL 9'h120
`define OFF_XFER_STAT 9'h124
`define OFF_FLAGS 9'h128
`define OFF_ITEM_SIZE 9'h12C

// Field positions
`define BIT_RX_EN 0
`define BIT_RX_DIS 1
`define BIT_TX_EN 8
`define BIT_TX_DIS 9
`define BIT_RX_END 0
`define BIT_TX_END 1
`define BIT_RX_FULL 2
`define BIT_TX_EMPTY 3

// Item sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Reset values
`define PTR_RESET 32'h0000_0000
`define CNT_RESET 16'h0000
`define SIZE_RESET 2'h2

`endif

/* dma_slot.v */
// Pointer, counter, enable and flag set of one peripheral's channels
`timescale 1ns/1ps
`include "peripheral_dma_consts.vh"

module dma_slot #(
   parameter [1:0] MODE = `MODE_FULL
) (
   input wire pclk,
   input wire presetn,
   input wire wr_en,
   input wire [8:0] wr_off,
   input wire [31:0] wr_data,
   input wire [8:0] rd_off,
   output reg [31:0] rd_data,
   input wire rx_step,
   input wire tx_step,
   output wire [63:0] cur_ptr_all,
   output wire [1:0] nz_all,
   output reg rx_en_reg,
   output reg tx_en_reg,
   output wire [1:0] end_all,
   output wire [1:0] buf_all,
   output reg [1:0] size_reg
);
   wire [63:0] nxt_ptr_all; // Index 0 receive, 1 transmit
   wire [31:0] cur_cnt_all;
   wire [31:0] nxt_cnt_all;
   wire [31:0] inc; // Address step per item
   wire w_ctrl;
   wire w_size;
   reg rx_en_next;
   reg tx_en_next;

   assign inc = (size_reg == `SIZE_BYTE) ? 32'h0000_0001 :
                (size_reg == `SIZE_HALF) ? 32'h0000_0002 :
                32'h0000_0004;
   assign w_ctrl = wr_en && (wr_off == `OFF_XFER_CTRL);
   assign w_size = wr_en && (wr_off == `OFF_ITEM_SIZE);

   // One pointer/counter set pair per direction
   genvar d;
   generate
      for (d = 0; d < 2; d = d + 1) begin : dir
         wire [8:0] o_cp = d ? `OFF_TX_CUR_PTR : `OFF_RX_CUR_PTR;
         wire [8:0] o_cc = d ? `OFF_TX_CUR_CNT : `OFF_RX_CUR_CNT;
         wire [8:0] o_np = d ? `OFF_TX_NXT_PTR : `OFF_RX_NXT_PTR;
         wire [8:0] o_nc = d ? `OFF_TX_NXT_CNT : `OFF_RX_NXT_CNT;
         reg [31:0] cp_reg;
         reg [31:0] np_reg;
         reg [15:0] cc_reg;
         reg [15:0] nc_reg;
         reg end_reg;
         reg buf_reg;
         wire step = d ? tx_step : rx_step;
         wire w_cp = wr_en && (wr_off == o_cp);
         wire w_cc = wr_en && (wr_off == o_cc);
         wire w_np = wr_en && (wr_off == o_np);
         wire w_nc = wr_en && (wr_off == o_nc);
         // Last item of the current buffer just moved
         wire last = step && (cc_reg == 16'h0001);
         // Idle reload covers a next set written after the stop
         wire idle = (cc_reg == `CNT_RESET) && !w_cc && !w_nc;
         wire reload = (last || idle) && (nc_reg != `CNT_RESET);
         wire clr = (w_cc && (wr_data[15:0] != `CNT_RESET)) ||
                    (w_nc && (wr_data[15:0] != `CNT_RESET));

         // Counters and pointers; a software write beats hardware
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cp_reg <= `PTR_RESET;
               np_reg <= `PTR_RESET;
               cc_reg <= `CNT_RESET;
               nc_reg <= `CNT_RESET;
               end_reg <= 1'b0;
               buf_reg <= 1'b0;
            end else begin
               if (w_cp) begin
                  cp_reg <= wr_data;
               end else if (reload) begin
                  cp_reg <= np_reg;
               end else if (step) begin
                  cp_reg <= cp_reg + inc;
               end
               if (w_cc) begin
                  cc_reg <= wr_data[15:0];
               end else if (reload) begin
                  cc_reg <= nc_reg;
               end else if (step) begin
                  cc_reg <= cc_reg - 16'h0001;
               end
               if (w_np) begin
                  np_reg <= wr_data;
               end else if (reload) begin
                  np_reg <= `PTR_RESET;
               end
               if (w_nc) begin
                  nc_reg <= wr_data[15:0];
               end else if (reload) begin
                  nc_reg <= `CNT_RESET;
               end
               // Set wins over a clear in the same cycle
               end_reg <= last | (end_reg & ~clr);
               buf_reg <= (last && (nc_reg == `CNT_RESET)) |
                          (buf_reg & ~clr);
            end
         end

         assign cur_ptr_all[d*32 +: 32] = cp_reg;
         assign nxt_ptr_all[d*32 +: 32] = np_reg;
         assign cur_cnt_all[d*16 +: 16] = cc_reg;
         assign nxt_cnt_all[d*16 +: 16] = nc_reg;
         assign nz_all[d] = (cc_reg != `CNT_RESET);
         assign end_all[d] = end_reg;
         assign buf_all[d] = buf_reg;
      end
   endgenerate

   // Enable decode; disable beats enable in one write
   always @* begin
      rx_en_next = rx_en_reg;
      tx_en_next = tx_en_reg;
      if (w_ctrl) begin
         if (wr_data[`BIT_RX_EN]) begin
            rx_en_next = 1'b1;
         end
         if (wr_data[`BIT_TX_EN]) begin
            tx_en_next = 1'b1;
         end
         // Half duplex: one direction only, receive wins a tie
         if (MODE == `MODE_HALF) begin
            if (wr_data[`BIT_RX_EN]) begin
               tx_en_next = 1'b0;
            end else if (wr_data[`BIT_TX_EN]) begin
               rx_en_next = 1'b0;
            end
         end
         if (wr_data[`BIT_RX_DIS]) begin
            rx_en_next = 1'b0;
         end
         if (wr_data[`BIT_TX_DIS]) begin
            tx_en_next = 1'b0;
         end
      end
      // Receive only slot has no transmit channel
      if (MODE == `MODE_RX_ONLY) begin
         tx_en_next = 1'b0;
      end
   end

   // Enable and item size registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_en_reg <= 1'b0;
         tx_en_reg <= 1'b0;
         size_reg <= `SIZE_RESET;
      end else begin
         rx_en_reg <= rx_en_next;
         tx_en_reg <= tx_en_next;
         if (w_size) begin
            size_reg <= wr_data[1:0];
         end
      end
   end

   // Register read mux; unlisted offsets and the control word read 0
   always @* begin
      rd_data = 32'h0000_0000;
      case (rd_off)
         `OFF_RX_CUR_PTR: rd_data = cur_ptr_all[31:0];
         `OFF_TX_CUR_PTR: rd_data = cur_ptr_all[63:32];
         `OFF_RX_NXT_PTR: rd_data = nxt_ptr_all[31:0];
         `OFF_TX_NXT_PTR: rd_data = nxt_ptr_all[63:32];
         `OFF_RX_CUR_CNT: rd_data[15:0] = cur_cnt_all[15:0];
         `OFF_TX_CUR_CNT: rd_data[15:0] = cur_cnt_all[31:16];
         `OFF_RX_NXT_CNT: rd_data[15:0] = nxt_cnt_all[15:0];
         `OFF_TX_NXT_CNT: rd_data[15:0] = nxt_cnt_all[31:16];
         `OFF_XFER_STAT: begin
            rd_data[`BIT_RX_EN] = rx_en_reg;
            rd_data[`BIT_TX_EN] = tx_en_reg;
         end
         `OFF_FLAGS: begin
            rd_data[`BIT_RX_END] = end_all[0];
            rd_data[`BIT_TX_END] = end_all[1];
            rd_data[`BIT_RX_FULL] = buf_all[0];
            rd_data[`BIT_TX_EMPTY] = buf_all[1];
         end
         `OFF_ITEM_SIZE: rd_data[1:0] = size_reg;
         default: rd_data = 32'h0000_0000;
      endcase
   end
endmodule

/* peripheral_dma_engine.v */
// Multi-channel peripheral DMA engine with APB register windows
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "peripheral_dma_consts.vh"

module peripheral_dma_engine (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [12:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [11:0] tx_req,
   input wire [11:0] rx_req,
   output reg pb_req,
   output reg pb_we,
   output reg [3:0] pb_slot,
   output reg [1:0] pb_size,
   output reg [31:0] pb_wdata,
   input wire [31:0] pb_rdata,
   input wire pb_ack,
   output reg mem_req,
   output reg mem_we,
   output reg [31:0] mem_addr,
   output reg [1:0] mem_size,
   output reg [31:0] mem_wdata,
   input wire [31:0] mem_rdata,
   input wire mem_ack,
   output wire [11:0] rx_end_flag,
   output wire [11:0] tx_end_flag,
   output wire [11:0] rx_buffer_full_flag,
   output wire [11:0] tx_buffer_empty_flag
);
   // Engine states
   localparam [2:0] ST_SCAN = 3'h0;
   localparam [2:0] ST_P_RD = 3'h1;
   localparam [2:0] ST_M_WR = 3'h2;
   localparam [2:0] ST_M_RD = 3'h3;
   localparam [2:0] ST_P_WR = 3'h4;
   localparam [2:0] ST_STEP = 3'h5;
   // Last scan position: two directions per slot
   localparam [4:0] LAST_CAND = 5'h17;

   reg [2:0] state_reg; // Engine state
   reg [4:0] cursor_reg; // Round-robin scan position
   reg [3:0] slot_reg; // Slot of the item in flight
   reg dir_reg; // 0 receive, 1 transmit

   wire [3:0] paddr_slot; // Peripheral window select
   wire [8:0] paddr_off; // Offset inside the window
   wire addr_ok; // Access hits a mapped register
   wire wr_commit; // Write takes effect this edge
   wire [32*`NUM_SLOTS-1:0] rd_all; // Read data from every slot
   wire [64*`NUM_SLOTS-1:0] ptr_all; // Current pointers, rx then tx
   wire [2*`NUM_SLOTS-1:0] nz_all; // Current count non-zero
   wire [11:0] rx_en_v; // Receive channel enabled
   wire [11:0] tx_en_v; // Transmit channel enabled
   wire [2*`NUM_SLOTS-1:0] end_all;
   wire [2*`NUM_SLOTS-1:0] buf_all;
   wire [2*`NUM_SLOTS-1:0] size_all;
   wire [11:0] rx_step_v; // One-cycle item-done strobes
   wire [11:0] tx_step_v;
   wire [3:0] c_slot; // Slot under the scan cursor
   wire c_dir; // Direction under the scan cursor
   wire c_ready; // Candidate may start an item
   wire [31:0] c_ptr; // Candidate's current pointer
   wire [1:0] c_size; // Candidate's item size

   // Window decode: each slot owns a 512-byte peripheral window
   assign paddr_slot = paddr[`SLOT_MSB:`SLOT_LSB];
   assign paddr_off = paddr[`SLOT_LSB-1:0];
   assign addr_ok = (paddr_slot < `NUM_SLOTS) &&
                    (paddr_off[1:0] == 2'h0) &&
                    (paddr_off >= `OFF_RX_CUR_PTR) &&
                    (paddr_off <= `OFF_ITEM_SIZE);
   assign wr_commit = psel && penable && pwrite && pready && addr_ok;

   // APB slave: one wait state, then pready with data or error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            // Unmapped reads return zero with an error
            if (!pwrite && addr_ok) begin
               prdata <= rd_all[paddr_slot*32 +: 32];
            end else begin
               prdata <= 32'h0000_0000;
            end
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // One register slot per served peripheral
   genvar i;
   generate
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin : slot
         localparam [1:0] SMODE = (i == `HDX_SLOT) ? `MODE_HALF :
                                  (i == `RXO_SLOT) ? `MODE_RX_ONLY :
                                  `MODE_FULL;
         dma_slot #(
            .MODE(SMODE)
         ) u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(wr_commit && (paddr_slot == i)),
            .wr_off(paddr_off),
            .wr_data(pwdata),
            .rd_off(paddr_off),
            .rd_data(rd_all[i*32 +: 32]),
            .rx_step(rx_step_v[i]),
            .tx_step(tx_step_v[i]),
            .cur_ptr_all(ptr_all[i*64 +: 64]),
            .nz_all(nz_all[i*2 +: 2]),
            .rx_en_reg(rx_en_v[i]),
            .tx_en_reg(tx_en_v[i]),
            .end_all(end_all[i*2 +: 2]),
            .buf_all(buf_all[i*2 +: 2]),
            .size_reg(size_all[i*2 +: 2])
         );
         // Item-done strobe goes back to the owning slot
         assign rx_step_v[i] = (state_reg == ST_STEP) && !dir_reg &&
                               (slot_reg == i);
         assign tx_step_v[i] = (state_reg == ST_STEP) && dir_reg &&
                               (slot_reg == i);
         // Flags go to the peripheral; it raises its own interrupt
         assign rx_end_flag[i] = end_all[i*2];
         assign tx_end_flag[i] = end_all[i*2+1];
         assign rx_buffer_full_flag[i] = buf_all[i*2];
         assign tx_buffer_empty_flag[i] = buf_all[i*2+1];
      end
   endgenerate

   // Candidate under the cursor: request, enable and data left
   assign c_slot = cursor_reg[4:1];
   assign c_dir = cursor_reg[0];
   assign c_ready = c_dir ?
      (tx_req[c_slot] && tx_en_v[c_slot] && nz_all[c_slot*2+1]) :
      (rx_req[c_slot] && rx_en_v[c_slot] && nz_all[c_slot*2]);
   assign c_ptr = ptr_all[c_slot*64 + c_dir*32 +: 32];
   assign c_size = size_all[c_slot*2 +: 2];

   // Transfer engine: one item per grant, cursor scans round robin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_SCAN;
         cursor_reg <= 5'h00;
         slot_reg <= 4'h0;
         dir_reg <= 1'b0;
         pb_req <= 1'b0;
         pb_we <= 1'b0;
         pb_slot <= 4'h0;
         pb_size <= `SIZE_RESET;
         pb_wdata <= 32'h0000_0000;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= `PTR_RESET;
         mem_size <= `SIZE_RESET;
         mem_wdata <= 32'h0000_0000;
      end else begin
         case (state_reg)
            ST_SCAN: begin
               // Cursor moves on either way, so no slot starves
               if (cursor_reg == LAST_CAND) begin
                  cursor_reg <= 5'h00;
               end else begin
                  cursor_reg <= cursor_reg + 5'h01;
               end
               if (c_ready) begin
                  slot_reg <= c_slot;
                  dir_reg <= c_dir;
                  // Pointer is taken now; later writes hit the next item
                  mem_addr <= c_ptr;
                  mem_size <= c_size;
                  pb_slot <= c_slot;
                  pb_size <= c_size;
                  if (c_dir) begin
                     // Transmit: fetch from memory first
                     mem_req <= 1'b1;
                     mem_we <= 1'b0;
                     state_reg <= ST_M_RD;
                  end else begin
                     // Receive: fetch holding register over the bridge
                     pb_req <= 1'b1;
                     pb_we <= 1'b0;
                     state_reg <= ST_P_RD;
                  end
               end
            end
            ST_P_RD: begin
               // Peripheral data arrives, forward it to memory
               if (pb_ack) begin
                  pb_req <= 1'b0;
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_wdata <= pb_rdata;
                  state_reg <= ST_M_WR;
               end
            end
            ST_M_WR: begin
               // Flags may only set once memory has the data
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  state_reg <= ST_STEP;
               end
            end
            ST_M_RD: begin
               // Memory data arrives, pass it to the peripheral
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  pb_req <= 1'b1;
                  pb_we <= 1'b1;
                  pb_wdata <= mem_rdata;
                  state_reg <= ST_P_WR;
               end
            end
            ST_P_WR: begin
               // Holding register written, item complete
               if (pb_ack) begin
                  pb_req <= 1'b0;
                  pb_we <= 1'b0;
                  state_reg <= ST_STEP;
               end
            end
            ST_STEP: begin
               // Slot counts the item down; also lets requests settle
               state_reg <= ST_SCAN;
            end
            default: begin
               state_reg <= ST_SCAN;
               pb_req <= 1'b0;
               mem_req <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* dma_far_side.sv */
// Far-side model: serial peripheral holding registers and system memory
`timescale 1ns/1ps
module dma_far_side (
   input wire pclk,
   input wire presetn,
   input wire slow,
   input wire pb_req,
   input wire mem_req,
   input wire [31:0] mem_addr,
   output reg [31:0] pb_rdata,
   output reg pb_ack,
   output reg [31:0] mem_rdata,
   output reg mem_ack
);
   reg [2:0] pb_wait; // Cycles a bridge access has waited
   reg [2:0] mem_wait; // Cycles a memory access has waited
   reg [31:0] seq; // Next item the peripheral hands over
   wire [2:0] lat = slow ? 3'h3 : 3'h0; // Slow mode stalls both sides
   // One-cycle ack per request; data toggles outside an ack so that
   // a stale bus value can never pass for a fresh one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pb_ack <= 1'b0;
         mem_ack <= 1'b0;
         pb_wait <= 3'h0;
         mem_wait <= 3'h0;
         pb_rdata <= 32'h0;
         mem_rdata <= 32'h0;
         seq <= 32'hA0;
      end else begin
         pb_ack <= 1'b0;
         mem_ack <= 1'b0;
         pb_rdata <= ~pb_rdata;
         mem_rdata <= ~mem_rdata;
         // Bridge side: holding register access
         if (pb_req && !pb_ack) begin
            pb_wait <= pb_wait + 3'h1;
            if (pb_wait >= lat) begin
               pb_ack <= 1'b1;
               pb_wait <= 3'h0;
               pb_rdata <= seq;
               seq <= seq + 32'h1;
            end
         end
         // Memory side: read data follows the address
         if (mem_req && !mem_ack) begin
            mem_wait <= mem_wait + 3'h1;
            if (mem_wait >= lat) begin
               mem_ack <= 1'b1;
               mem_wait <= 3'h0;
               mem_rdata <= mem_addr ^ 32'h5A5A_0000;
            end
         end
      end
   end
endmodule

/* dma_engine_asserts.sv */
// Port checks of the DMA engine's APB and item traffic
`timescale 1ns/1ps
module dma_engine_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [12:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire pb_req,
   input wire pb_we,
   input wire [31:0] pb_wdata,
   input wire [31:0] pb_rdata,
   input wire pb_ack,
   input wire mem_req,
   input wire mem_we,
   input wire [31:0] mem_addr,
   input wire [31:0] mem_wdata,
   input wire [31:0] mem_rdata,
   input wire mem_ack,
   input wire [11:0] rx_end_flag,
   input wire [11:0] tx_end_flag,
   input wire [11:0] rx_buffer_full_flag,
   input wire [11:0] tx_buffer_empty_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Address hits a register inside one of the twelve windows
   wire mapped = paddr[12:9] < 4'hC && paddr[8:0] >= 9'h100 &&
      paddr[8:0] <= 9'h12C && paddr[1:0] == 2'h0;
   AST_APB_ONE_WAIT:
   assert property (psel && penable && !$past(penable) |-> !pready ##1
      pready) else $error("apb wait state wrong");
   AST_UNMAPPED_ERR:
   assert property (pready |-> pslverr == !mapped)
      else $error("slave error wrong");
   AST_ONE_SIDE:
   assert property (!(pb_req && mem_req)) else $error("both sides busy");
   AST_PB_HOLD:
   assert property (pb_req && !pb_ack |=> pb_req && $stable(pb_we) &&
      $stable(pb_wdata)) else $error("bridge request moved");
   AST_MEM_HOLD:
   assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_we)
      && $stable(mem_addr) && $stable(mem_wdata))
      else $error("memory request moved");
   AST_RX_TO_MEM:
   assert property (pb_req && pb_ack && !pb_we |=> !pb_req && mem_req &&
      mem_we && mem_wdata == $past(pb_rdata)) else $error("rx item lost");
   AST_TX_TO_PB:
   assert property (mem_req && mem_ack && !mem_we |=> !mem_req && pb_req
      && pb_we && pb_wdata == $past(mem_rdata)) else $error("tx item lost");
   AST_BUF_NEEDS_END:
   assert property (((rx_buffer_full_flag & ~rx_end_flag) |
      (tx_buffer_empty_flag & ~tx_end_flag)) == 12'h0)
      else $error("buffer flag without end flag");
   AST_RX_END_CAUSE:
   assert property ((rx_end_flag & ~$past(rx_end_flag)) != 12'h0 |->
      $past(mem_ack) || $past(mem_ack, 2) || $past(mem_ack, 3))
      else $error("rx end without memory write");
   AST_TX_END_CAUSE:
   assert property ((tx_end_flag & ~$past(tx_end_flag)) != 12'h0 |->
      $past(pb_ack) || $past(pb_ack, 2) || $past(pb_ack, 3))
      else $error("tx end without peripheral write");
endmodule
bind peripheral_dma_engine dma_engine_checker dma_engine_checker_i (.*);

/* testbench.sv */
// Self-checking bench: register rows, transfers, flags, reset
`timescale 1ns/1ps
module testbench;
   reg pclk, presetn, psel, penable, pwrite, slow;
   reg [12:0] paddr;
   reg [31:0] pwdata;
   reg [11:0] tx_req, rx_req;
   wire [31:0] prdata, pb_wdata, pb_rdata, mem_addr, mem_wdata, mem_rdata;
   wire pready, pslverr, pb_req, pb_we, pb_ack, mem_req, mem_we, mem_ack;
   wire [3:0] pb_slot;
   wire [1:0] pb_size, mem_size;
   wire [11:0] rx_end_flag, tx_end_flag;
   wire [11:0] rx_buffer_full_flag, tx_buffer_empty_flag;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] addr_q[$]; // Memory addresses in ack order
   logic [3:0] slot_seen; // Slot of the last bridge access
   logic [1:0] size_seen; // Item size of the last memory access
   typedef struct {bit wr; logic [12:0] a; logic [31:0] d, e; bit er;} row_t;
   // Write rows load; read rows expect data and error flag
   row_t rows [14] = '{
      '{0, 13'h0100, 32'h0, 32'h0, 0}, // Pointer reset
      '{0, 13'h012C, 32'h0, 32'h2, 0}, // Item size resets to word
      '{1, 13'h0108, 32'h1234_5678, 32'h0, 0},
      '{0, 13'h0108, 32'h0, 32'h1234_5678, 0},
      '{1, 13'h010C, 32'hABCD_0005, 32'h0, 0},
      '{0, 13'h010C, 32'h0, 32'h5, 0}, // Counter keeps 16 bits
      '{1, 13'h1710, 32'h8765_4320, 32'h0, 0},
      '{0, 13'h1710, 32'h0, 32'h8765_4320, 0}, // Half duplex next ptr
      '{1, 13'h1520, 32'h101, 32'h0, 0},
      '{0, 13'h1524, 32'h0, 32'h1, 0}, // Receive-only slot drops tx
      '{0, 13'h0120, 32'h0, 32'h0, 0}, // Control reads zero
      '{0, 13'h1800, 32'h0, 32'h0, 1}, // No slot 12
      '{0, 13'h00FC, 32'h0, 32'h0, 1}, // Below the window
      '{0, 13'h0102, 32'h0, 32'h0, 1}}; // Unaligned
   peripheral_dma_engine peripheral_dma_engine_i (.*);
   dma_far_side dma_far_side_i (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Logs memory addresses and bridge slots as acks land
   always @(posedge pclk) begin
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
         addr_q.push_back(mem_addr);
         size_seen = mem_size;
      end
      if (pb_ack === 1'b1)
         slot_seen = pb_slot;
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // APB transfer held until pready is seen at a rising edge
   task apb(input bit wr, input logic [12:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      // A slave that never answers counts as a mismatch
      if (pready !== 1'b1)
         n_mismatch++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [12:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input string nm, input logic [12:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
   endtask
   // Waits, bounded, for n memory acks, then for the counter update
   task wait_q(input int n);
      int k;
      k = 0;
      while (addr_q.size() < n && k < 400) begin
         @(posedge pclk);
         k++;
      end
      chk("item count", n, addr_q.size());
      repeat (4) @(posedge pclk);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs under 500 cycles; forty times that means a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      print_verdict;
   end
   initial begin
      logic [31:0] r;
      logic e;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 13'h0;
      pwdata = 32'h0;
      tx_req = 12'h0;
      rx_req = 12'h0;
      slow = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d, r, e);
         chk("slave error", {31'h0, rows[i].er}, {31'h0, e});
         if (!rows[i].wr)
            chk("read data", rows[i].e, r);
      end
      $display("test register rows done");
      // Receive, half-words, one reload from the next pair, slow far side
      wr(13'h052C, 32'h1);
      wr(13'h0500, 32'h2000_0000);
      wr(13'h0504, 32'h1);
      wr(13'h0510, 32'h3000_0000);
      wr(13'h0514, 32'h2);
      addr_q.delete();
      rx_req[2] <= 1'b1;
      wr(13'h0520, 32'h1);
      wait_q(3);
      chk("rx addr 0", 32'h2000_0000, addr_q[0]);
      chk("rx addr 1", 32'h3000_0000, addr_q[1]);
      chk("rx addr 2", 32'h3000_0002, addr_q[2]);
      rd("rx cur ptr", 13'h0500, 32'h3000_0004);
      rd("rx next cnt", 13'h0514, 32'h0);
      chk("rx full pin", 32'h1, rx_buffer_full_flag[2]);
      chk("rx end pin", 32'h1, rx_end_flag[2]);
      chk("rx size", 32'h1, size_seen);
      rd("rx flags", 13'h0528, 32'h5);
      // Zero count write keeps flags; non-zero clears them
      wr(13'h0514, 32'h0);
      rd("flags kept", 13'h0528, 32'h5);
      wr(13'h0520, 32'h2);
      wr(13'h0504, 32'h1);
      rd("flags cleared", 13'h0528, 32'h0);
      $display("test receive reload done");
      // Transmit bytes, prompt far side
      slow <= 1'b0;
      wr(13'h072C, 32'h0);
      wr(13'h0708, 32'h4000_0000);
      wr(13'h070C, 32'h2);
      addr_q.delete();
      tx_req[3] <= 1'b1;
      wr(13'h0720, 32'h100);
      rd("tx status", 13'h0724, 32'h100);
      wait_q(2);
      chk("tx addr 0", 32'h4000_0000, addr_q[0]);
      chk("tx addr 1", 32'h4000_0001, addr_q[1]);
      chk("bridge slot", 32'h3, slot_seen);
      chk("tx empty pin", 32'h1, tx_buffer_empty_flag[3]);
      chk("tx end pin", 32'h1, tx_end_flag[3]);
      chk("tx size", 32'h0, size_seen);
      rd("tx cur cnt", 13'h070C, 32'h0);
      $display("test transmit bytes done");
      // Half duplex: enabling tx drops rx, then one word goes out
      wr(13'h1720, 32'h1);
      wr(13'h1720, 32'h100);
      rd("half status", 13'h1724, 32'h100);
      wr(13'h1708, 32'h5000_0000);
      addr_q.delete();
      tx_req[11] <= 1'b1;
      wr(13'h170C, 32'h1);
      wait_q(1);
      chk("half addr", 32'h5000_0000, addr_q[0]);
      rd("half ptr", 13'h1708, 32'h5000_0004);
      $display("test half duplex done");
      // Reset in mid-run restores register values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("ptr after reset", 13'h0108, 32'h0);
      rd("size after reset", 13'h072C, 32'h2);
      $display("test second reset done");
      print_verdict;
   end
endmodule
